// [umc_defs.svh]
// Constants for the serial port mode-control block
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH

// ********************************************************
// Register map (byte addresses)
// ********************************************************
`define UMC_ADDR_W          4
`define UMC_OFS_MODE        4'h0
`define UMC_OFS_STATUS      4'h4
`define UMC_RESET_MODE      16'h0000
`define UMC_READ_ZERO       32'h0000_0000

// ********************************************************
// Mode register fields
// ********************************************************
`define UMC_BIT_ON          15
`define UMC_BIT_STOP_IN_IDLE        13
`define UMC_BIT_INFRARED_ENABLE        12
`define UMC_BIT_REQUEST_PIN_MODE       11
`define UMC_PINSEL_HI       9
`define UMC_PINSEL_LO       8
`define UMC_BIT_WAKE        7
`define UMC_BIT_LOOPBACK_SELECT      6
`define UMC_BIT_AUTO_RATE_DETECT       5
`define UMC_BIT_RECEIVE_POLARITY_INVERT       4
`define UMC_BIT_HIGH_RATE_SELECT        3
`define UMC_PARITY_DATA_SELECT_HI        2
`define UMC_PARITY_DATA_SELECT_LO        1
`define UMC_BIT_STOP_BIT_SELECT       0
// Writable bits; 14 and 10 are unimplemented
`define UMC_MODE_WMASK      16'hbbff

// ********************************************************
// Pin-enable encodings
// ********************************************************
`define UMC_PINS_TXRX       2'h0
`define UMC_PINS_RTS        2'h1
`define UMC_PINS_CTSRTS     2'h2
`define UMC_PINS_BCLK       2'h3

// ********************************************************
// Infrared timing, in 16x sub-bit ticks
// ********************************************************
`define UMC_IR_TICKS_BIT    4'hf
`define UMC_IR_PULSE_TICKS  4'h3
`define UMC_IR_PH_W         4

`endif

// [umc_irda_codec.sv]
// Infrared pulse encoder and decoder for the serial path
`timescale 1ns/1ps
`include "umc_defs.svh"
module umc_irda_codec
  import umc_pkg::*;
#(
  parameter int PH_W = `UMC_IR_PH_W
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic tick16,
  input  wire logic bit_start,
  input  wire logic tx_bit,
  input  wire logic ir_rx_n,
  output logic      ir_tx_ff,
  output logic      rx_bit_ff
);

  logic [PH_W-1:0] tx_phase_ff;
  logic [PH_W-1:0] rx_hold_ff;
  logic            rx_busy_ff;

  // ********************************************************
  // Encoder: a zero bit becomes a short high pulse
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      tx_phase_ff <= '0;
    end else if (bit_start) begin
      tx_phase_ff <= '0;
    end else if (tick16 && tx_phase_ff != PH_W'(`UMC_IR_TICKS_BIT)) begin
      tx_phase_ff <= tx_phase_ff + PH_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      ir_tx_ff <= 1'b0;
    end else begin
      ir_tx_ff <= !tx_bit && !bit_start && (tx_phase_ff < PH_W'(`UMC_IR_PULSE_TICKS));
    end
  end

  // ********************************************************
  // Decoder: a low pulse stretches to one low bit time
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      rx_busy_ff <= 1'b0;
      rx_hold_ff <= '0;
    end else if (!ir_rx_n) begin
      rx_busy_ff <= 1'b1;
      rx_hold_ff <= '0;
    end else if (rx_busy_ff && tick16) begin
      rx_hold_ff <= rx_hold_ff + PH_W'(1);
      if (rx_hold_ff == PH_W'(`UMC_IR_TICKS_BIT)) begin
        rx_busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      rx_bit_ff <= 1'b1;
    end else begin
      rx_bit_ff <= !(rx_busy_ff || !ir_rx_n);
    end
  end

endmodule

// [umc_mode_control.sv]
// Serial port mode register, pin ownership, idle, wake and loopback control
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "umc_defs.svh"
module umc_mode_control
  import umc_pkg::*;
#(
  parameter int NPINS = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic        transmit_enable_bit,
  input  wire logic        core_tx_bit,
  input  wire logic        core_bit_start,
  input  wire logic        core_tick16,
  input  wire logic        core_tx_busy,
  input  wire logic        core_rx_ready,
  input  wire logic        core_baud_clock,
  output logic             core_rx_bit,
  output logic             core_cts,
  output logic             core_run,
  output umc_mode_s        core_mode,
  output logic             wake_request,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  input  wire logic [3:0]  pad_in,
  output logic      [3:0]  pad_out,
  output logic      [3:0]  pad_oe
);

  // ********************************************************
  // Bus access state
  // ********************************************************
  typedef enum logic [2:0] {
    UMC_BUS_IDLE = 3'b001,
    UMC_BUS_ACK  = 3'b010,
    UMC_BUS_DONE = 3'b100
  } umc_bus_e;

  umc_bus_e        bus_state_ff;
  umc_bus_e        nxt_bus_state;
  logic            wait_ff;
  logic [31:0]     rdata_ff;
  logic [15:0]     mode_ff;
  logic [15:0]     nxt_mode;
  umc_mode_s       mode_view;
  logic            run_ff;
  logic            rx_prev_ff;
  logic            wake_ff;
  logic            rx_core_ff;
  logic            cts_ff;
  logic            stopped_ff;
  umc_pin_ctl_s    pin_ctl;
  logic            ir_tx;
  logic            ir_rx;
  logic            line_tx;
  logic            line_rx;
  logic            req;
  logic            accept;

  assign req    = avs_read || avs_write;
  assign accept = req && (bus_state_ff == UMC_BUS_ACK);

  // ********************************************************
  // Field view and decoding helpers
  // ********************************************************
  function automatic umc_mode_s unpack_mode(input logic [15:0] m);
    umc_mode_s s;
    s.module_on               = m[`UMC_BIT_ON];
    s.stop_in_idle            = m[`UMC_BIT_STOP_IN_IDLE];
    s.infrared_enable         = m[`UMC_BIT_INFRARED_ENABLE];
    s.request_pin_mode        = m[`UMC_BIT_REQUEST_PIN_MODE];
    s.pin_enable_select       = m[`UMC_PINSEL_HI:`UMC_PINSEL_LO];
    s.wake_enable             = m[`UMC_BIT_WAKE];
    s.loopback_select         = m[`UMC_BIT_LOOPBACK_SELECT];
    s.auto_rate_detect        = m[`UMC_BIT_AUTO_RATE_DETECT];
    s.receive_polarity_invert = m[`UMC_BIT_RECEIVE_POLARITY_INVERT];
    s.high_rate_select        = m[`UMC_BIT_HIGH_RATE_SELECT];
    s.parity_data_select      = m[`UMC_PARITY_DATA_SELECT_HI:`UMC_PARITY_DATA_SELECT_LO];
    s.stop_bit_select         = m[`UMC_BIT_STOP_BIT_SELECT];
    return s;
  endfunction

  // Which pins the port owns, indexed by umc_pin_e
  function automatic logic [3:0] owned_pins(input umc_mode_s s, input logic txen);
    logic [3:0] o;
    o = 4'h0;
    if (s.module_on) begin
      o[UMC_PIN_TX] = txen;
      o[UMC_PIN_RX] = 1'b1;
      if (s.pin_enable_select == `UMC_PINS_CTSRTS) begin
        o[UMC_PIN_CTS]  = 1'b1;
        o[UMC_PIN_RTSB] = 1'b1;
      end else if (s.pin_enable_select == `UMC_PINS_RTS) begin
        o[UMC_PIN_RTSB] = 1'b1;
      end else if (s.pin_enable_select == `UMC_PINS_BCLK) begin
        o[UMC_PIN_RTSB] = 1'b1;
      end
    end
    return o;
  endfunction

  assign mode_view = unpack_mode(mode_ff);

  // ********************************************************
  // Avalon slave: one wait state, then answer
  // ********************************************************
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      UMC_BUS_IDLE: begin
        if (req) begin
          nxt_bus_state = UMC_BUS_ACK;
        end
      end
      UMC_BUS_ACK: begin
        nxt_bus_state = UMC_BUS_DONE;
      end
      UMC_BUS_DONE: begin
        nxt_bus_state = UMC_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = UMC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state_ff <= UMC_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Waitrequest drops for exactly the cycle after the request is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(req && bus_state_ff == UMC_BUS_IDLE);
    end
  end

  // Read data is captured one edge early so it stands at the accepting edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= `UMC_READ_ZERO;
    end else if (avs_read && bus_state_ff == UMC_BUS_IDLE) begin
      if (avs_address == `UMC_OFS_MODE) begin
        rdata_ff <= {16'h0000, mode_ff};
      end else if (avs_address == `UMC_OFS_STATUS) begin
        rdata_ff <= {24'h00_0000, 1'b0, wake_ff, stopped_ff, run_ff, pin_ctl.own};
      end else begin
        rdata_ff <= `UMC_READ_ZERO;
      end
    end
  end

  // ********************************************************
  // Mode register
  // ********************************************************
  always_comb begin
    nxt_mode = mode_ff;
    if (accept && avs_write && avs_address == `UMC_OFS_MODE) begin
      if (avs_byteenable[0]) begin
        nxt_mode[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        nxt_mode[15:8] = avs_writedata[15:8];
      end
      nxt_mode = nxt_mode & `UMC_MODE_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= `UMC_RESET_MODE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ********************************************************
  // Run gating for Idle and disable
  // ********************************************************
  // Data path clocks are enabled only by core_run, which keeps a
  // disabled port from toggling anything; an idle-stopped port still drives its owned pins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_ff     <= 1'b0;
      stopped_ff <= 1'b0;
    end else begin
      run_ff     <= mode_view.module_on && !(mode_view.stop_in_idle && idle_mode);
      stopped_ff <= mode_view.module_on && mode_view.stop_in_idle && idle_mode;
    end
  end

  // ********************************************************
  // Start-bit wake from Sleep
  // ********************************************************
  // A falling receive line while asleep raises wake until Sleep ends;
  // the request is held so a slow power manager cannot miss it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= line_rx;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_ff <= 1'b0;
    end else if (!sleep_mode || !mode_view.wake_enable || !mode_view.module_on) begin
      wake_ff <= 1'b0;
    end else if (rx_prev_ff && !line_rx) begin
      wake_ff <= 1'b1;
    end
  end

  // ********************************************************
  // Serial path: infrared codec, polarity and loopback
  // ********************************************************
  umc_irda_codec #(
    .PH_W (`UMC_IR_PH_W)
  ) u_irda (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .enable    (run_ff && mode_view.infrared_enable),
    .tick16    (core_tick16),
    .bit_start (core_bit_start),
    .tx_bit    (core_tx_bit),
    .ir_rx_n   (pad_in[UMC_PIN_RX]),
    .ir_tx_ff  (ir_tx),
    .rx_bit_ff (ir_rx)
  );

  assign line_tx = mode_view.infrared_enable ? ir_tx : core_tx_bit;
  assign line_rx = mode_view.infrared_enable ? ir_rx : pad_in[UMC_PIN_RX];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_core_ff <= 1'b1;
    end else if (!run_ff) begin
      rx_core_ff <= 1'b1;
    end else if (mode_view.loopback_select) begin
      rx_core_ff <= core_tx_bit;
    end else begin
      rx_core_ff <= line_rx ^ mode_view.receive_polarity_invert;
    end
  end

  // Clear-to-send is only heard when the port owns that pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cts_ff <= 1'b0;
    end else if (pin_ctl.own[UMC_PIN_CTS]) begin
      cts_ff <= pad_in[UMC_PIN_CTS];
    end else begin
      cts_ff <= 1'b0;
    end
  end

  // ********************************************************
  // Pin drive values
  // ********************************************************
  always_comb begin
    pin_ctl.own = owned_pins(mode_view, transmit_enable_bit);
    pin_ctl.port_out = 4'h0;
    pin_ctl.port_oe  = 4'h0;
    // Loopback holds the transmit pin at idle so the peer sees no data
    pin_ctl.port_out[UMC_PIN_TX] = mode_view.loopback_select ? 1'b1 : line_tx;
    pin_ctl.port_oe[UMC_PIN_TX]  = 1'b1;
    if (mode_view.pin_enable_select == `UMC_PINS_BCLK) begin
      pin_ctl.port_out[UMC_PIN_RTSB] = core_baud_clock;
    end else if (mode_view.request_pin_mode) begin
      pin_ctl.port_out[UMC_PIN_RTSB] = !core_tx_busy;
    end else begin
      pin_ctl.port_out[UMC_PIN_RTSB] = !core_rx_ready;
    end
    pin_ctl.port_oe[UMC_PIN_RTSB] = 1'b1;
  end

  umc_pin_mux #(
    .NPINS (NPINS)
  ) u_pins (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .own        (pin_ctl.own),
    .port_out   (pin_ctl.port_out),
    .port_oe    (pin_ctl.port_oe),
    .gpio_out   (gpio_out),
    .gpio_oe    (gpio_oe),
    .pad_out_ff (pad_out),
    .pad_oe_ff  (pad_oe)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign core_rx_bit     = rx_core_ff;
  assign core_cts        = cts_ff;
  assign core_run        = run_ff;
  assign wake_request    = wake_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_mode <= unpack_mode(`UMC_RESET_MODE);
    end else begin
      core_mode <= unpack_mode(nxt_mode);
    end
  end

endmodule

// [umc_mode_control_monitor.sv]
// Assertion checker for the serial port mode-control block
`timescale 1ns/1ps
module umc_mode_control_monitor
  import umc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        idle_mode,
  input wire logic        sleep_mode,
  input wire logic        core_tx_bit,
  input wire logic        core_tx_busy,
  input wire logic        core_rx_ready,
  input wire logic        core_rx_bit,
  input wire logic        core_run,
  input wire umc_mode_s   core_mode,
  input wire logic        wake_request,
  input wire logic [3:0]  gpio_out,
  input wire logic [3:0]  gpio_oe,
  input wire logic [3:0]  pad_out,
  input wire logic [3:0]  pad_oe
);
  logic       on;
  logic [1:0] sel;
  logic       run_exp;
  logic       rts_exp;
  logic       wake_en;
  logic       loop_ok;
  assign on      = core_mode.module_on;
  assign sel     = core_mode.pin_enable_select;
  assign run_exp = on && !(core_mode.stop_in_idle && idle_mode);
  assign rts_exp = core_mode.request_pin_mode ? !core_tx_busy : !core_rx_ready;
  assign wake_en = core_mode.wake_enable;
  // Registered and combinational run agree, so no edge case at turn-on
  assign loop_ok = core_run && run_exp && core_mode.loopback_select &&
                   !core_mode.infrared_enable && !core_mode.receive_polarity_invert;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ********
  // Checks
  // ********
  a_read_answer:
    assert property ($rose(avs_read) |-> ##1 !avs_waitrequest)
    else $error("read not answered at the next edge");
  a_upper_zero:
    assert property (avs_read && !avs_waitrequest |-> (avs_readdata & 32'hffff_4400) == 32'h0)
    else $error("unimplemented mode bits read nonzero");
  a_reset_clear:
    assert property (disable iff (1'b0) rst |=> core_mode == '0 && !core_run && !wake_request)
    else $error("state not cleared by reset");
  a_off_release:
    assert property (!on |=> pad_oe == $past(gpio_oe) && pad_out == $past(gpio_out))
    else $error("disabled port still holds pins");
  a_cts_gpio:
    assert property (on && sel != 2'h2 |=> pad_oe[2] == $past(gpio_oe[2]))
    else $error("handshake input pin taken outside select 10");
  a_pin3_gpio:
    assert property (on && sel == 2'h0 |=> pad_oe[3] == $past(gpio_oe[3]))
    else $error("pin 3 taken with select 00");
  a_rts_mode:
    assert property (on && (sel == 2'h1 || sel == 2'h2) |=> pad_out[3] == $past(rts_exp))
    else $error("request pin level wrong for its mode");
  a_run_idle:
    assert property (1'b1 |=> core_run == $past(run_exp))
    else $error("run state does not follow enable and idle");
  a_wake_cause:
    assert property ($rose(wake_request) |-> $past(wake_en) && $past(sleep_mode))
    else $error("wake raised without enable in sleep");
  a_wake_clear:
    assert property (!sleep_mode |=> !wake_request)
    else $error("wake held after sleep ended");
  a_loop_echo:
    assert property (loop_ok |=> core_rx_bit == $past(core_tx_bit))
    else $error("loopback does not echo transmit bit");

  c_baud_pin: cover property (on && sel == 2'h3);
  c_wake:     cover property ($rose(wake_request));
  c_loop:     cover property (loop_ok);
endmodule

bind umc_mode_control umc_mode_control_monitor mon (
  .sys_clk, .rst, .avs_read, .avs_readdata, .avs_waitrequest, .idle_mode, .sleep_mode,
  .core_tx_bit, .core_tx_busy, .core_rx_ready, .core_rx_bit, .core_run, .core_mode,
  .wake_request, .gpio_out, .gpio_oe, .pad_out, .pad_oe
);

// [umc_mode_control_tb_top.sv]
// Self-checking testbench for the serial port mode-control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module umc_mode_control_tb_top
  import umc_pkg::*;
;
  logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest, idle_mode, sleep_mode;
  logic        transmit_enable_bit, core_tx_bit, core_tick16, core_tx_busy, core_rx_ready;
  logic        core_baud_clock, core_rx_bit, core_cts, core_run, wake_request;
  logic        rx_drive, cts_drive, core_bit_start;
  logic [3:0]  avs_address, avs_byteenable, gpio_out, gpio_oe, pad_in, pad_out, pad_oe;
  logic [31:0] avs_writedata, avs_readdata, q;
  umc_mode_s   core_mode;
  int          num_errors, checks_done, n;

  umc_mode_control dut (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .idle_mode, .sleep_mode, .transmit_enable_bit,
    .core_tx_bit, .core_bit_start, .core_tick16, .core_tx_busy, .core_rx_ready,
    .core_baud_clock, .core_rx_bit, .core_cts, .core_run, .core_mode, .wake_request,
    .gpio_out, .gpio_oe, .pad_in, .pad_out, .pad_oe
  );
  umc_serial_peer peer (.pad_out, .pad_oe, .rx_drive, .cts_drive, .pad_in);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Free-running data-path stimulus
  always @(posedge sys_clk) begin
    core_baud_clock <= ~core_baud_clock;
    core_tick16     <= ~core_tick16;
    core_tx_bit     <= ~core_tx_bit;
  end

  // ********
  // Tasks
  // ********
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // One bus access; entered and left just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    r = avs_readdata;
    if (k >= 50) begin
      num_errors++;
      test_done();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    {rst, rx_drive, cts_drive, transmit_enable_bit} = 4'hf;
    {avs_read, avs_write, idle_mode, sleep_mode, core_tx_busy, core_bit_start} = 6'h00;
    {core_tx_bit, core_tick16, core_baud_clock, core_rx_ready} = 4'h1;
    {avs_address, avs_writedata, avs_byteenable} = {4'h0, 32'h0, 4'hf};
    {gpio_out, gpio_oe, num_errors, checks_done} = {4'ha, 4'he, 64'h0};
    tick(8);
    rst <= 1'b0;
    tick(2);
    bus(0, 4'h0, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK(core_mode, 14'h0)
    `CHK(pad_oe, 4'he)
    bus(1, 4'h0, 32'hffff_ffff, q);
    bus(0, 4'h0, 32'h0, q);
    `CHK(q, 32'h0000_bbff)
    `CHK(core_mode, 14'h3fff)
    bus(1, 4'h8, 32'h0, q);
    bus(0, 4'h8, 32'h0, q);
    `CHK(q, 32'h0)
    bus(0, 4'h0, 32'h0, q);
    `CHK(q, 32'h0000_bbff)
    // Every pin selection, both request-pin modes
    for (int i = 0; i < 8; i++) begin
      bus(1, 4'h0, {16'h0, 1'b1, 3'h0, i[2], 1'b0, i[1:0], 8'h00}, q);
      tick(4);
      `CHK(pad_oe, {1'b1, i[1:0] != 2'h2, 2'b01})
      `CHK(core_cts, i[1:0] == 2'h2)
      `CHK(pad_out[3], (i[1:0] == 2'h3) ? !core_baud_clock : (i[1:0] == 2'h0 || i[2]))
      bus(0, 4'h4, 32'h0, q);
      `CHK(q[3:0], {i[1:0] != 2'h0, i[1:0] == 2'h2, 2'b11})
    end
    transmit_enable_bit <= 1'b0;
    tick(3);
    `CHK(pad_oe[0], 1'b0)
    transmit_enable_bit <= 1'b1;
    bus(1, 4'h0, 32'h0, q);
    gpio_out <= 4'h5;
    tick(3);
    `CHK({pad_out, pad_oe, core_run}, 9'h0bc)
    // Stop-in-idle against idle state
    for (int j = 0; j < 4; j++) begin
      bus(1, 4'h0, {16'h0, 2'b10, j[0], 13'h0}, q);
      idle_mode <= j[1];
      tick(3);
      `CHK(core_run, !(j[0] && j[1]))
    end
    idle_mode <= 1'b0;
    bus(1, 4'h0, 32'h0000_8040, q);
    tick(3);
    `CHK(pad_out[0], 1'b1)
    `CHK(core_rx_bit, !core_tx_bit)
    // Start-bit wake, enabled and disabled
    for (int k = 0; k < 2; k++) begin
      bus(1, 4'h0, k ? 32'h0000_8080 : 32'h0000_8000, q);
      sleep_mode <= 1'b1;
      tick(2);
      rx_drive <= 1'b0;
      for (n = 0; n < 12 && wake_request !== 1'b1; n++) @(posedge sys_clk);
      `CHK(wake_request, k[0])
      sleep_mode <= 1'b0;
      rx_drive   <= 1'b1;
      tick(2);
      `CHK(wake_request, 1'b0)
    end
    // Infrared decoder stretches a short low pulse
    for (int k = 0; k < 2; k++) begin
      bus(1, 4'h0, k ? 32'h0000_9000 : 32'h0000_8000, q);
      tick(40);
      // Encoder idles low once the pulse phase has run out, pulses after a bit start
      if (k) begin
        `CHK(pad_out[0], 1'b0)
        core_bit_start <= 1'b1;
        tick(1);
        core_bit_start <= 1'b0;
        n = 0;
        repeat (8) begin
          tick(1);
          n += pad_out[0];
        end
        `CHK(n != 0, 1'b1)
      end
      rx_drive <= 1'b0;
      tick(2);
      rx_drive <= 1'b1;
      for (n = 0; n < 12 && core_rx_bit !== 1'b0; n++) @(posedge sys_clk);
      tick(8);
      `CHK(core_rx_bit, !k[0])
    end
    test_done();
  end
endmodule

// [umc_pin_mux.sv]
// Per-pin choice between the serial port and the general-purpose port
`timescale 1ns/1ps
module umc_pin_mux
  import umc_pkg::*;
#(
  parameter int NPINS = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [NPINS-1:0] own,
  input  wire logic [NPINS-1:0] port_out,
  input  wire logic [NPINS-1:0] port_oe,
  input  wire logic [NPINS-1:0] gpio_out,
  input  wire logic [NPINS-1:0] gpio_oe,
  output logic      [NPINS-1:0] pad_out_ff,
  output logic      [NPINS-1:0] pad_oe_ff
);

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pad_out_ff[i] <= 1'b0;
          pad_oe_ff[i]  <= 1'b0;
        end else if (own[i]) begin
          pad_out_ff[i] <= port_out[i];
          pad_oe_ff[i]  <= port_oe[i];
        end else begin
          pad_out_ff[i] <= gpio_out[i];
          pad_oe_ff[i]  <= gpio_oe[i];
        end
      end
    end
  endgenerate

endmodule

// [umc_pkg.sv]
// Types shared by the serial port mode-control block
package umc_pkg;

  typedef struct packed {
    logic       module_on;
    logic       stop_in_idle;
    logic       infrared_enable;
    logic       request_pin_mode;
    logic [1:0] pin_enable_select;
    logic       wake_enable;
    logic       loopback_select;
    logic       auto_rate_detect;
    logic       receive_polarity_invert;
    logic       high_rate_select;
    logic [1:0] parity_data_select;
    logic       stop_bit_select;
  } umc_mode_s;

  // Pin index order used by the pin multiplexer
  typedef enum logic [1:0] {
    UMC_PIN_TX   = 2'h0,
    UMC_PIN_RX   = 2'h1,
    UMC_PIN_CTS  = 2'h2,
    UMC_PIN_RTSB = 2'h3
  } umc_pin_e;

  typedef struct packed {
    logic [3:0] own;
    logic [3:0] port_out;
    logic [3:0] port_oe;
  } umc_pin_ctl_s;

endpackage

// [umc_serial_peer.sv]
// Far-side serial peer that drives the pad inputs
`timescale 1ns/1ps
module umc_serial_peer (
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe,
  input  wire logic       rx_drive,
  input  wire logic       cts_drive,
  output logic      [3:0] pad_in
);
  // Undriven output pins read inverted so a stale value never looks right
  always_comb begin
    pad_in[0] = pad_oe[0] ? pad_out[0] : ~pad_out[0];
    pad_in[1] = pad_oe[1] ? pad_out[1] : rx_drive;
    pad_in[2] = pad_oe[2] ? pad_out[2] : cts_drive;
    pad_in[3] = pad_oe[3] ? pad_out[3] : ~pad_out[3];
  end
endmodule
